/* rtl/dihpm_top.sv */
/*
 pin multiplexer for the decoder index pin (port c line two) and the
 decoder home pin (port c line three); steers decoder, timer b,
 spi one and port c.
 assumes one 40 MHz clock, synchronous active-low reset, pads with
 separate in/out/oe signals, configuration bits driven by on-chip
 registers on the same clock.
*/
// Notes on behaviour
// (R1) full variant: index pin defaults to decoder
// (R2) full variant: home pin defaults to decoder
// (R3) reduced variant: software must reprogram both pins
// (R4) index pull-up on at reset, cleared bit off
// (R5) home pull-up on at reset, cleared bit off
// (R6) index alternate bit selects spi return line
// (R7) home alternate bit selects spi slave select
// (R8) return line input as master, output slave
// (R9) unselected slave floats its return line
// (R10) slave presents bit half cycle before sample
// (R11) master mode: slave select detects contention
// (R12) slave mode: slave select addresses device
// (R13) port function direction programmable per pin
// (R14) otherwise decoder input, timer per configuration
`timescale 1ns/1ps
module dihpm_top (
   input  wire logic       sys_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       full_variant_in,
   input  wire logic       index_pin_alternate_bit_in,
   input  wire logic       home_pin_alternate_bit_in,
   input  wire logic [7:0] port_c_pullup_register_in,
   input  wire logic [1:0] port_sel_in,
   input  wire logic [1:0] port_dir_out_in,
   input  wire logic [1:0] port_data_in,
   input  wire logic [1:0] timer_sel_in,
   input  wire logic [1:0] timer_b_out_in,
   input  wire logic [1:0] timer_b_oe_in,
   input  wire logic       spi_master_in,
   input  wire logic       spi_one_return_line_tx_in,
   input  wire logic [1:0] pad_i_in,
   output logic      [1:0] pad_o_out,
   output logic      [1:0] pad_oe_n_out,
   output logic      [1:0] pad_pullup_out,
   output logic            decoder_index_input_out,
   output logic            decoder_home_input_out,
   output logic      [1:0] timer_b_in_out,
   output logic            spi_one_return_line_rx_out,
   output logic            spi_one_slave_select_n_out,
   output logic            spi_one_mode_fault_out,
   output logic      [1:0] port_c_in_out
);
   // =====================================================================
   // pad synchroniser
   // =====================================================================
   logic [1:0] sync1_q, sync1_d, sync2_q, sync2_d;

   always_comb begin
      sync1_d = pad_i_in;
      sync2_d = sync1_q;
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         sync1_q <= 2'h3;
         sync2_q <= 2'h3;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
      end
   end

   // =====================================================================
   // per-pin slices
   // =====================================================================
   dihpm_pkg::dihpm_cfg_s cfg [2];
   dihpm_pkg::dihpm_drv_s drv [2];
   dihpm_pkg::dihpm_fn_e  fn  [2];
   logic [1:0]            o_c, oe_n_c, pu_c;
   logic                  slave_sel_c;
   logic                  spi_return_oe_c;

   // return line drives only as a selected slave  [R8] [R9] [R12]
   assign spi_return_oe_c = !spi_master_in && slave_sel_c;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_pin
         localparam int unsigned PB = (g == 0) ? dihpm_pkg::INDEX_PIN_BIT
                                               : dihpm_pkg::HOME_PIN_BIT;
         always_comb begin
            cfg[g].alternate_bit = (g == 0) ? index_pin_alternate_bit_in  // [R6]
                                            : home_pin_alternate_bit_in;  // [R7]
            cfg[g].port_sel      = port_sel_in[g];
            cfg[g].port_dir_out  = port_dir_out_in[g];
            cfg[g].timer_sel     = timer_sel_in[g];
            cfg[g].pullup_en     = port_c_pullup_register_in[PB];  // [R4] [R5]
            drv[g].timer_out     = timer_b_out_in[g];
            drv[g].timer_oe      = timer_b_oe_in[g];
            // slave select pin is input only
            drv[g].spi_out       = (g == 0) ? spi_one_return_line_tx_in : 1'b0;
            drv[g].spi_oe        = (g == 0) ? spi_return_oe_c : 1'b0;
            drv[g].port_out      = port_data_in[g];
         end

         dihpm_pin_slice u_slice (
            .full_variant_in (full_variant_in),
            .cfg_in          (cfg[g]),
            .drv_in          (drv[g]),
            .fn_out          (fn[g]),
            .pad_o_out       (o_c[g]),
            .pad_oe_n_out    (oe_n_c[g]),
            .pullup_out      (pu_c[g])
         );
      end
   endgenerate

   // slave select seen by the spi, active high; idle low when pin not routed
   assign slave_sel_c = (fn[1] == dihpm_pkg::DIHPM_FN_SPI) && !sync2_q[1];  // [R12]

   // =====================================================================
   // registered outputs
   // =====================================================================
   logic [1:0] pad_o_q, pad_o_d, pad_oe_n_q, pad_oe_n_d, pu_q, pu_d;
   logic [1:0] tmr_q, tmr_d, port_q, port_d;
   logic       idx_q, idx_d, home_q, home_d, rx_q, rx_d;
   logic       ss_n_q, ss_n_d, fault_q, fault_d;

   function automatic logic routed(input dihpm_pkg::dihpm_fn_e f,
                                   input dihpm_pkg::dihpm_fn_e want,
                                   input logic lvl, input logic idle);
      routed = (f == want) ? lvl : idle;
   endfunction : routed

   always_comb begin
      pad_o_d    = o_c;
      pad_oe_n_d = oe_n_c;  // [R13]
      pu_d       = pu_c;  // [R4] [R5]
      idx_d      = routed(fn[0], dihpm_pkg::DIHPM_FN_DECODER, sync2_q[0], 1'b0);  // [R1]
      home_d     = routed(fn[1], dihpm_pkg::DIHPM_FN_DECODER, sync2_q[1], 1'b0);  // [R2]
      tmr_d[0]   = routed(fn[0], dihpm_pkg::DIHPM_FN_TIMER, sync2_q[0], 1'b0);
      tmr_d[1]   = routed(fn[1], dihpm_pkg::DIHPM_FN_TIMER, sync2_q[1], 1'b0);
      port_d[0]  = routed(fn[0], dihpm_pkg::DIHPM_FN_PORT, sync2_q[0], 1'b0);
      port_d[1]  = routed(fn[1], dihpm_pkg::DIHPM_FN_PORT, sync2_q[1], 1'b0);
      // master samples the slave's bit, which was presented half a
      // spi clock earlier by the far slave  [R10]
      rx_d       = routed(fn[0], dihpm_pkg::DIHPM_FN_SPI,
                          sync2_q[0] & spi_master_in, 1'b0);  // [R6] [R8]
      ss_n_d     = !slave_sel_c;  // [R7] [R12]
      // low slave select while master means another master  [R11]
      fault_d    = spi_master_in && (fn[1] == dihpm_pkg::DIHPM_FN_SPI)
                   && !sync2_q[1];
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         pad_o_q    <= 2'h0;
         pad_oe_n_q <= 2'h3;
         pu_q       <= 2'h3;  // pull-ups on during reset  [R4] [R5]
         idx_q      <= 1'b0;
         home_q     <= 1'b0;
         tmr_q      <= 2'h0;
         port_q     <= 2'h0;
         rx_q       <= 1'b0;
         ss_n_q     <= 1'b1;
         fault_q    <= 1'b0;
      end else begin
         pad_o_q    <= pad_o_d;
         pad_oe_n_q <= pad_oe_n_d;
         pu_q       <= pu_d;
         idx_q      <= idx_d;
         home_q     <= home_d;
         tmr_q      <= tmr_d;
         port_q     <= port_d;
         rx_q       <= rx_d;
         ss_n_q     <= ss_n_d;
         fault_q    <= fault_d;
      end
   end

   assign pad_o_out                  = pad_o_q;
   assign pad_oe_n_out               = pad_oe_n_q;
   assign pad_pullup_out             = pu_q;
   assign decoder_index_input_out    = idx_q;
   assign decoder_home_input_out     = home_q;
   assign timer_b_in_out             = tmr_q;
   assign spi_one_return_line_rx_out = rx_q;
   assign spi_one_slave_select_n_out = ss_n_q;
   assign spi_one_mode_fault_out     = fault_q;
   assign port_c_in_out              = port_q;
endmodule : dihpm_top

/* rtl/dihpm_pkg.sv */
/*
 package for the decoder index / home pin multiplexer.
 assumes a single 40 MHz system clock domain.
*/
package dihpm_pkg;
   // =====================================================================
   // port c bit positions and reset values
   // =====================================================================
   localparam int unsigned INDEX_PIN_BIT      = 2;
   localparam int unsigned HOME_PIN_BIT       = 3;
   localparam logic [7:0]  PULLUP_RESET       = 8'h0C;
   localparam logic        ALT_RESET          = 1'b0;
   localparam logic        GPIO_SEL_RESET     = 1'b0;
   localparam logic        GPIO_DIR_RESET     = 1'b0;
   localparam logic        TIMER_SEL_RESET    = 1'b0;

   // =====================================================================
   // function of a shared pin
   // =====================================================================
   typedef enum logic [3:0] {
      DIHPM_FN_DECODER = 4'h1,
      DIHPM_FN_TIMER   = 4'h2,
      DIHPM_FN_SPI     = 4'h4,
      DIHPM_FN_PORT    = 4'h8
   } dihpm_fn_e;

   // per-pin configuration bits
   typedef struct packed {
      logic alternate_bit;
      logic port_sel;
      logic port_dir_out;
      logic timer_sel;
      logic pullup_en;
   } dihpm_cfg_s;

   // internal peripheral side of one pin
   typedef struct packed {
      logic timer_out;
      logic timer_oe;
      logic spi_out;
      logic spi_oe;
      logic port_out;
   } dihpm_drv_s;
endpackage : dihpm_pkg

/* rtl/dihpm_pin_slice.sv */
/*
 one shared pad: function select, pad drive and pull-up.
 assumes the synchronised pad level is supplied by the parent.
*/
`timescale 1ns/1ps
module dihpm_pin_slice (
   input  wire logic                  full_variant_in,
   input  wire dihpm_pkg::dihpm_cfg_s cfg_in,
   input  wire dihpm_pkg::dihpm_drv_s drv_in,
   output dihpm_pkg::dihpm_fn_e       fn_out,
   output logic                       pad_o_out,
   output logic                       pad_oe_n_out,
   output logic                       pullup_out
);
   // =====================================================================
   // function decode
   // =====================================================================
   always_comb begin
      if (cfg_in.alternate_bit) begin
         fn_out = dihpm_pkg::DIHPM_FN_SPI;
      end else if (cfg_in.port_sel || !full_variant_in) begin
         // reduced variant: port until software reprograms  [R3]
         fn_out = dihpm_pkg::DIHPM_FN_PORT;
      end else if (cfg_in.timer_sel) begin
         fn_out = dihpm_pkg::DIHPM_FN_TIMER;  // [R14]
      end else begin
         fn_out = dihpm_pkg::DIHPM_FN_DECODER;  // [R1] [R2] [R14]
      end
   end

   // =====================================================================
   // pad drive, oe active low
   // =====================================================================
   always_comb begin
      pad_o_out    = 1'b0;
      pad_oe_n_out = 1'b1;
      unique case (fn_out)
         dihpm_pkg::DIHPM_FN_TIMER: begin
            pad_o_out    = drv_in.timer_out;
            pad_oe_n_out = !drv_in.timer_oe;
         end
         dihpm_pkg::DIHPM_FN_SPI: begin
            pad_o_out    = drv_in.spi_out;
            pad_oe_n_out = !drv_in.spi_oe;  // [R8] [R9]
         end
         dihpm_pkg::DIHPM_FN_PORT: begin
            pad_o_out    = drv_in.port_out;
            pad_oe_n_out = !cfg_in.port_dir_out;  // [R13]
         end
         default: begin
            pad_o_out    = 1'b0;
            pad_oe_n_out = 1'b1;
         end
      endcase
      // pull-up only useful while nothing drives the pad
      pullup_out = cfg_in.pullup_en;  // [R4] [R5]
   end
endmodule : dihpm_pin_slice

/* sim/dihpm_pad_model.sv */
/*
 external side of the two shared pads: an outside spi master or line driver.
 assumes pad_oe_n is active low and the pull-up wins over a floating pad.
*/
`timescale 1ns/1ps
module dihpm_pad_model (
   input  wire logic       clk_in,
   input  wire logic [1:0] pad_o_in,
   input  wire logic [1:0] pad_oe_n_in,
   input  wire logic [1:0] pullup_in,
   input  wire logic [1:0] ext_en_in,
   input  wire logic [1:0] ext_val_in,
   output logic      [1:0] pad_lvl_out
);
   logic [1:0] float_q = 2'h0;
   // no driver, no pull: keep moving so a stale level is never seen as valid
   always @(posedge clk_in) float_q <= ~float_q;
   always_comb begin
      for (int k = 0; k < 2; k++) begin
         if (!pad_oe_n_in[k]) pad_lvl_out[k] = pad_o_in[k];
         else if (ext_en_in[k]) pad_lvl_out[k] = ext_val_in[k];
         else pad_lvl_out[k] = pullup_in[k] | float_q[k];
      end
   end
endmodule : dihpm_pad_model

/* sim/dihpm_chk.sv */
/*
 checker for the index / home pin multiplexer.
 assumes 2-flop pad sync plus output register: pad effects land 3 edges later.
*/
`timescale 1ns/1ps
module dihpm_chk (
   input wire logic       sys_clk_in,
   input wire logic       rst_n_in,
   input wire logic       full_variant_in,
   input wire logic       index_pin_alternate_bit_in,
   input wire logic       home_pin_alternate_bit_in,
   input wire logic [7:0] port_c_pullup_register_in,
   input wire logic [1:0] port_sel_in,
   input wire logic [1:0] port_dir_out_in,
   input wire logic [1:0] timer_sel_in,
   input wire logic       spi_master_in,
   input wire logic       spi_one_return_line_tx_in,
   input wire logic [1:0] pad_i_in,
   input wire logic [1:0] pad_o_out,
   input wire logic [1:0] pad_oe_n_out,
   input wire logic [1:0] pad_pullup_out,
   input wire logic       decoder_index_input_out,
   input wire logic       decoder_home_input_out,
   input wire logic       spi_one_return_line_rx_out,
   input wire logic       spi_one_slave_select_n_out,
   input wire logic       spi_one_mode_fault_out
);
   default clocking dc @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   logic slv, mst, idx_dec, home_dec;
   assign slv = index_pin_alternate_bit_in & home_pin_alternate_bit_in & ~spi_master_in;
   assign mst = index_pin_alternate_bit_in & spi_master_in;
   assign idx_dec = full_variant_in & ~index_pin_alternate_bit_in & ~port_sel_in[0]
                    & ~timer_sel_in[0];
   assign home_dec = full_variant_in & ~home_pin_alternate_bit_in & ~port_sel_in[1]
                     & ~timer_sel_in[1];
   sequence s_selected; (slv && !pad_i_in[1])[*4]; endsequence
   sequence s_unselected; (slv && pad_i_in[1])[*4]; endsequence
   // =====================================================================
   // assertions
   // =====================================================================
   a_idx_pullup:
      assert property ($past(rst_n_in) |-> pad_pullup_out[0] ==
         $past(port_c_pullup_register_in[2])) else $error("index pull-up wrong");
   a_home_pullup:
      assert property ($past(rst_n_in) |-> pad_pullup_out[1] ==
         $past(port_c_pullup_register_in[3])) else $error("home pull-up wrong");
   a_slave_drives:
      assert property (s_selected |-> !pad_oe_n_out[0] &&
         pad_o_out[0] == $past(spi_one_return_line_tx_in)) else $error("slave not driving");
   a_slave_floats:
      assert property (s_unselected |-> pad_oe_n_out[0]) else $error("unselected drives");
   a_master_rx:
      assert property ((mst && $stable(pad_i_in[0]))[*4] |-> pad_oe_n_out[0] &&
         spi_one_return_line_rx_out == pad_i_in[0]) else $error("master rx wrong");
   a_mode_fault:
      assert property ((home_pin_alternate_bit_in && spi_master_in && !pad_i_in[1])[*4]
         |-> spi_one_mode_fault_out) else $error("fault missed");
   a_select_follow:
      assert property ((home_pin_alternate_bit_in && $stable(pad_i_in[1]))[*4] |->
         pad_oe_n_out[1] && spi_one_slave_select_n_out == pad_i_in[1])
         else $error("select wrong");
   a_port_dir:
      assert property ($past(rst_n_in) && $past(port_sel_in[0] && !index_pin_alternate_bit_in)
         |-> pad_oe_n_out[0] == !$past(port_dir_out_in[0])) else $error("port dir wrong");
   a_index_dec:
      assert property ((idx_dec && $stable(pad_i_in[0]))[*4] |->
         decoder_index_input_out == pad_i_in[0]) else $error("index decoder wrong");
   a_home_dec:
      assert property ((home_dec && $stable(pad_i_in[1]))[*4] |->
         decoder_home_input_out == pad_i_in[1]) else $error("home decoder wrong");
endmodule : dihpm_chk

bind dihpm_top dihpm_chk u_dihpm_chk (.sys_clk_in, .rst_n_in, .full_variant_in,
   .index_pin_alternate_bit_in, .home_pin_alternate_bit_in, .port_c_pullup_register_in,
   .port_sel_in, .port_dir_out_in, .timer_sel_in, .spi_master_in,
   .spi_one_return_line_tx_in, .pad_i_in, .pad_o_out, .pad_oe_n_out, .pad_pullup_out,
   .decoder_index_input_out, .decoder_home_input_out, .spi_one_return_line_rx_out,
   .spi_one_slave_select_n_out, .spi_one_mode_fault_out);

/* sim/testbench.sv */
/*
 self-checking bench for the index / home pin multiplexer.
 assumes pad effects settle within 4 cycles; timer b drive comes from the bench.
*/
`timescale 1ns/1ps
module testbench;
   logic        clk = 1'b0, rst_n = 1'b0, full, ialt, halt, mst, tx;
   logic [7:0]  pur = 8'h0C;
   logic [1:0]  tbo = 2'h0, tbe = 2'h0;
   logic [1:0]  psel, pdir, pdat, tsel, xen, xval, pad_i, pad_o, oe_n, pull, tin, pin;
   logic        dix, dho, rx, ssn, flt;
   int          fail_count = 0, n_compared = 0, cyc = 0;
   // row: {full ialt halt mst, psel pdir, pdat tsel, xen xval, tx 000, expected 12 bits}
   logic [31:0] rows [10] = '{32'h8000_0F10, 32'h800C_0C10, 32'h803E_0C90, 32'h8F80_0012,
      32'h8C0D_0C11, 32'h000E_0C12, 32'hF00F_0C30, 32'hF00C_0C08, 32'hE008_8800,
      32'hE00A_8C10};
   always #12.5 clk = ~clk;
   dihpm_top u_dihpm_top (.sys_clk_in(clk), .rst_n_in(rst_n), .full_variant_in(full),
      .index_pin_alternate_bit_in(ialt), .home_pin_alternate_bit_in(halt),
      .port_c_pullup_register_in(pur), .port_sel_in(psel), .port_dir_out_in(pdir),
      .port_data_in(pdat), .timer_sel_in(tsel), .timer_b_out_in(tbo),
      .timer_b_oe_in(tbe), .spi_master_in(mst), .spi_one_return_line_tx_in(tx),
      .pad_i_in(pad_i), .pad_o_out(pad_o), .pad_oe_n_out(oe_n), .pad_pullup_out(pull),
      .decoder_index_input_out(dix), .decoder_home_input_out(dho), .timer_b_in_out(tin),
      .spi_one_return_line_rx_out(rx), .spi_one_slave_select_n_out(ssn),
      .spi_one_mode_fault_out(flt), .port_c_in_out(pin));
   dihpm_pad_model u_dihpm_pad_model (.clk_in(clk), .pad_o_in(pad_o), .pad_oe_n_in(oe_n),
      .pullup_in(pull), .ext_en_in(xen), .ext_val_in(xval), .pad_lvl_out(pad_i));
   // =====================================================================
   // checking and closing
   // =====================================================================
   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic test_done;
      if (fail_count == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : test_done
   // a full run takes about 100 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 1000) begin
         fail_count++;
         test_done();
      end
   end
   // =====================================================================
   // stimulus
   // =====================================================================
   initial begin
      {full, ialt, halt, mst, psel, pdir, pdat, tsel, xen, xval, tx} = 17'h1_0000;
      repeat (20) @(negedge clk);
      check({oe_n, pull, pad_o, ssn, dix, dho, rx, flt, 1'b0}, 12'hF20);
      rst_n = 1'b1;
      foreach (rows[i]) begin
         @(negedge clk);
         {full, ialt, halt, mst, psel, pdir, pdat, tsel, xen, xval, tx} = rows[i][31:15];
         repeat (5) @(negedge clk);
         check({oe_n, dix, dho, tin, rx, ssn, flt, 1'b0, pin}, rows[i][11:0]);
      end
      // pull-ups dropped one at a time
      pur = 8'h08;
      repeat (2) @(negedge clk);
      check({10'h000, pull}, 12'h002);
      pur = 8'h04;
      repeat (2) @(negedge clk);
      check({10'h000, pull}, 12'h001);
      pur = 8'h0C;
      // timer channels driving both pads, read back through the sync
      {full, ialt, halt, mst, psel, pdir, pdat, tsel, xen, xval, tx} = 17'h1_0000;
      tsel = 2'h3;
      tbo = 2'h1;
      tbe = 2'h3;
      repeat (5) @(negedge clk);
      check({6'h00, oe_n, pad_o, tin}, 12'h005);
      tbe = 2'h0;
      // reset in mid-run
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      check({oe_n, pull, pad_o, ssn, dix, dho, rx, flt, 1'b0}, 12'hF20);
      rst_n = 1'b1;
      {full, ialt, halt, mst, psel, pdir, pdat, tsel, xen, xval, tx} = 17'h1_0000;
      repeat (5) @(negedge clk);
      check({oe_n, dix, dho, tin, rx, ssn, flt, 1'b0, pin}, 12'hF10);
      test_done();
   end
endmodule : testbench
